// ===== logic/ocpwm_unit.sv
// Output compare and PWM channel with register port
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ocpwm_params.svh"

module ocpwm_unit #(
	parameter int CHANNEL = 1
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Register port
	input  wire logic [3:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out,
	// Time base and system
	input  wire logic [4:0]  timer_tick_in,
	input  wire logic        cpu_idle_in,
	input  wire logic        sync_event_in,
	input  wire logic        trigger_event_in,
	// Fault pins, active low
	input  wire logic        fault_pin_a_n_in,
	input  wire logic        fault_pin_b_n_in,
	// Output
	output logic             compare_output_pin_out,
	output logic             compare_event_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ocpwm_pkg::ocpwm_ctrl_one_t ctrl_one;
	ocpwm_pkg::ocpwm_ctrl_one_t next_ctrl_one;
	ocpwm_pkg::ocpwm_ctrl_two_t ctrl_two;
	ocpwm_pkg::ocpwm_ctrl_two_t next_ctrl_two;
	ocpwm_pkg::ocpwm_seq_t      seq;
	ocpwm_pkg::ocpwm_seq_t      next_seq;

	logic [15:0] primary_compare_value;
	logic [15:0] next_primary_compare_value;
	logic [15:0] secondary_compare_value;
	logic [15:0] next_secondary_compare_value;
	logic [15:0] timer_period;
	logic [15:0] next_timer_period;
	logic [15:0] primary_shadow;
	logic [15:0] next_primary_shadow;
	logic [15:0] secondary_shadow;
	logic [15:0] next_secondary_shadow;
	logic        fault_active;
	logic        next_fault_active;
	logic        next_pin;
	logic        next_event;
	logic [15:0] next_rdata;

	// ----------------------------------------
	// Decode and shared terms
	// ----------------------------------------
	logic        wr_one;
	logic        wr_two;
	logic        pwm_mode;
	logic [2:0]  mode;
	logic [2:0]  wr_mode;
	logic        tick;
	logic        period_end;
	logic [15:0] internal_counter;
	logic        primary_match;
	logic        secondary_match;
	logic        hold_clear;
	logic        sync_reset;
	logic [1:0]  fault_sync;
	logic        fault_raw;
	logic        fault_event;

	assign mode    = ctrl_one.compare_mode_select;
	assign wr_mode = wdata_in[`OCPWM_C1_MODE_HI:`OCPWM_C1_MODE_LO];

	always_comb begin
		wr_one = 1'b0;
		wr_two = 1'b0;
		if (wr_in && (addr_in == `OCPWM_ADDR_CTRL_ONE)) begin
			wr_one = 1'b1;
		end else if (wr_in && (addr_in == `OCPWM_ADDR_CTRL_TWO)) begin
			wr_two = 1'b1;
		end
	end

	assign pwm_mode = (mode == `OCPWM_MODE_PWM_EDGE) || (mode == `OCPWM_MODE_PWM_CENTER);

	// Counter held clear while disabled or waiting for a trigger
	assign hold_clear = (mode == `OCPWM_MODE_OFF)
		|| (ctrl_two.trigger_or_sync_select && !ctrl_two.trigger_running_status);
	// Self-sync needs no external reset: the period match already restarts it
	assign sync_reset = sync_event_in && !ctrl_two.trigger_or_sync_select
		&& (ctrl_two.sync_source_select != `OCPWM_SYNC_NONE)
		&& (ctrl_two.sync_source_select != `OCPWM_SYNC_SELF);

	ocpwm_time_base u_time_base (
		.clk_in              (clk_in),
		.nrst_in             (nrst_in),
		.timer_tick_in       (timer_tick_in),
		.time_base_select_in (ctrl_one.time_base_select),
		.halt_in             (cpu_idle_in && ctrl_one.idle_halt_control),
		.hold_clear_in       (hold_clear),
		.sync_reset_in       (sync_reset),
		.timer_period_in     (timer_period),
		.tick_out            (tick),
		.period_end_out      (period_end),
		.count_out           (internal_counter)
	);

	assign primary_match   = tick && (internal_counter == primary_compare_value);
	assign secondary_match = tick && (internal_counter == secondary_compare_value);

	// ----------------------------------------
	// Fault input
	// ----------------------------------------
	ocpwm_sync2 #(
		.WIDTH (2)
	) u_fault_sync (
		.clk_in   (clk_in),
		.nrst_in  (nrst_in),
		.async_in ({fault_pin_b_n_in, fault_pin_a_n_in}),
		.sync_out (fault_sync)
	);

	assign fault_raw   = (CHANNEL <= `OCPWM_FAULT_A_LAST) ? !fault_sync[0] : !fault_sync[1];
	assign fault_event = fault_raw && ctrl_one.fault_zero_input_enable && pwm_mode;

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_comb begin
		next_ctrl_one = ctrl_one;
		next_ctrl_two = ctrl_two;
		next_fault_active = fault_active;
		if (wr_one) begin
			next_ctrl_one.idle_halt_control         = wdata_in[`OCPWM_C1_IDLE_BIT];
			next_ctrl_one.time_base_select          =
				wdata_in[`OCPWM_C1_TSEL_HI:`OCPWM_C1_TSEL_LO];
			next_ctrl_one.fault_zero_input_enable   = wdata_in[`OCPWM_C1_FLTEN_BIT];
			next_ctrl_one.trigger_status_clear_mode = wdata_in[`OCPWM_C1_TRIGMD_BIT];
			next_ctrl_one.compare_mode_select       = wr_mode;
			// Software may only clear the flag, and only in hold mode
			if (ctrl_two.fault_hold_mode && !wdata_in[`OCPWM_C1_FLAG_BIT]) begin
				next_ctrl_one.pwm_fault_status_flag = 1'b0;
			end
		end
		if (wr_two) begin
			next_ctrl_two.fault_hold_mode        = wdata_in[`OCPWM_C2_HOLD_BIT];
			next_ctrl_two.fault_output_level     = wdata_in[`OCPWM_C2_LEVEL_BIT];
			next_ctrl_two.trigger_or_sync_select = wdata_in[`OCPWM_C2_TRIGSEL_BIT];
			next_ctrl_two.trigger_running_status = wdata_in[`OCPWM_C2_STAT_BIT];
			next_ctrl_two.sync_source_select     =
				wdata_in[`OCPWM_C2_SYNC_HI:`OCPWM_C2_SYNC_LO];
		end
		// Hardware clear of trigger status, then set, so the set wins
		if (ctrl_one.trigger_status_clear_mode && tick
			&& (secondary_compare_value == internal_counter)) begin
			next_ctrl_two.trigger_running_status = 1'b0;
		end
		if (trigger_event_in && ctrl_two.trigger_or_sync_select) begin
			next_ctrl_two.trigger_running_status = 1'b1;
		end
		// Fault state ends per hold mode once the source is gone
		if (fault_active && !fault_raw) begin
			if (!ctrl_two.fault_hold_mode && period_end) begin
				next_fault_active = 1'b0;
				next_ctrl_one.pwm_fault_status_flag = 1'b0;
			end else if (ctrl_two.fault_hold_mode && !ctrl_one.pwm_fault_status_flag) begin
				next_fault_active = 1'b0;
			end
		end
		if (!pwm_mode) begin
			next_fault_active = 1'b0;
		end
		if (fault_event) begin
			next_fault_active = 1'b1;
			if (mode == `OCPWM_MODE_PWM_CENTER) begin
				next_ctrl_one.pwm_fault_status_flag = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Compare values and shadows
	// ----------------------------------------
	always_comb begin
		next_primary_compare_value   = primary_compare_value;
		next_secondary_compare_value = secondary_compare_value;
		next_timer_period            = timer_period;
		if (wr_in && (addr_in == `OCPWM_ADDR_PRIMARY)) begin
			next_primary_compare_value = wdata_in;
		end else if (wr_in && (addr_in == `OCPWM_ADDR_SECONDARY)) begin
			next_secondary_compare_value = wdata_in;
		end else if (wr_in && (addr_in == `OCPWM_ADDR_PERIOD)) begin
			next_timer_period = wdata_in;
		end
		next_primary_shadow   = primary_shadow;
		next_secondary_shadow = secondary_shadow;
		// Outside PWM the shadows track live values, so PWM entry starts clean
		if (!pwm_mode || period_end) begin
			next_primary_shadow   = primary_compare_value;
			next_secondary_shadow = secondary_compare_value;
		end
	end

	// ----------------------------------------
	// Output waveform
	// ----------------------------------------
	always_comb begin
		next_pin   = compare_output_pin_out;
		next_seq   = seq;
		next_event = 1'b0;
		if (wr_one) begin
			// Rewriting the register re-arms single-shot modes
			next_seq = ocpwm_pkg::OCPWM_WAIT_PRIMARY;
			next_pin = (wr_mode == `OCPWM_MODE_SS_LOW);
			if ((wr_mode == `OCPWM_MODE_TOGGLE) && (wr_mode == mode)) begin
				next_pin = compare_output_pin_out;
			end
		end else begin
			case (mode)
				`OCPWM_MODE_OFF: begin
					next_pin = 1'b0;
				end
				`OCPWM_MODE_SS_HIGH: begin
					if (primary_match && (seq == ocpwm_pkg::OCPWM_WAIT_PRIMARY)) begin
						next_pin   = 1'b1;
						next_seq   = ocpwm_pkg::OCPWM_DONE;
						next_event = 1'b1;
					end
				end
				`OCPWM_MODE_SS_LOW: begin
					if (primary_match && (seq == ocpwm_pkg::OCPWM_WAIT_PRIMARY)) begin
						next_pin   = 1'b0;
						next_seq   = ocpwm_pkg::OCPWM_DONE;
						next_event = 1'b1;
					end
				end
				`OCPWM_MODE_TOGGLE: begin
					if (primary_match) begin
						next_pin   = !compare_output_pin_out;
						next_event = 1'b1;
					end
				end
				`OCPWM_MODE_DBL_ONE, `OCPWM_MODE_DBL_CONT: begin
					if (primary_match && (seq == ocpwm_pkg::OCPWM_WAIT_PRIMARY)) begin
						next_pin = !compare_output_pin_out;
						next_seq = ocpwm_pkg::OCPWM_WAIT_SECONDARY;
					end else if (secondary_match
						&& (seq == ocpwm_pkg::OCPWM_WAIT_SECONDARY)) begin
						next_pin   = !compare_output_pin_out;
						next_event = 1'b1;
						next_seq   = (mode == `OCPWM_MODE_DBL_CONT) ?
							ocpwm_pkg::OCPWM_WAIT_PRIMARY : ocpwm_pkg::OCPWM_DONE;
					end
				end
				default: begin
					if (fault_active) begin
						next_pin = ctrl_two.fault_output_level;
					end else if (secondary_shadow > timer_period) begin
						next_pin = 1'b1;
					end else if (mode == `OCPWM_MODE_PWM_CENTER) begin
						next_pin = (internal_counter >= primary_shadow)
							&& (internal_counter < secondary_shadow);
					end else begin
						next_pin = (internal_counter < secondary_shadow);
					end
					next_event = period_end;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read data, valid only the cycle after a read
	// ----------------------------------------
	always_comb begin
		next_rdata = 16'h0000;
		if (rd_in) begin
			if (addr_in == `OCPWM_ADDR_CTRL_ONE) begin
				next_rdata = {2'b00, ctrl_one.idle_halt_control, ctrl_one.time_base_select,
					2'b00, ctrl_one.fault_zero_input_enable, 2'b00,
					ctrl_one.pwm_fault_status_flag, ctrl_one.trigger_status_clear_mode,
					ctrl_one.compare_mode_select};
			end else if (addr_in == `OCPWM_ADDR_CTRL_TWO) begin
				next_rdata = {ctrl_two.fault_hold_mode, ctrl_two.fault_output_level, 6'h00,
					ctrl_two.trigger_or_sync_select, ctrl_two.trigger_running_status, 1'b0,
					ctrl_two.sync_source_select};
			end else if (addr_in == `OCPWM_ADDR_PRIMARY) begin
				next_rdata = primary_compare_value;
			end else if (addr_in == `OCPWM_ADDR_SECONDARY) begin
				next_rdata = secondary_compare_value;
			end else if (addr_in == `OCPWM_ADDR_PERIOD) begin
				next_rdata = timer_period;
			end else if (addr_in == `OCPWM_ADDR_COUNT) begin
				next_rdata = internal_counter;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_one                         <= `OCPWM_CTRL_ONE_RST;
			ctrl_two.fault_hold_mode         <= 1'b0;
			ctrl_two.fault_output_level      <= 1'b0;
			ctrl_two.trigger_or_sync_select  <= 1'b0;
			ctrl_two.trigger_running_status  <= 1'b0;
			ctrl_two.sync_source_select      <= `OCPWM_SYNC_SEL_RST;
			seq                              <= ocpwm_pkg::OCPWM_WAIT_PRIMARY;
			primary_compare_value            <= `OCPWM_WORD_RST;
			secondary_compare_value          <= `OCPWM_WORD_RST;
			timer_period                     <= `OCPWM_WORD_RST;
			primary_shadow                   <= `OCPWM_WORD_RST;
			secondary_shadow                 <= `OCPWM_WORD_RST;
			fault_active                     <= 1'b0;
			compare_output_pin_out           <= 1'b0;
			compare_event_out                <= 1'b0;
			rdata_out                        <= `OCPWM_WORD_RST;
		end else begin
			ctrl_one                         <= next_ctrl_one;
			ctrl_two                         <= next_ctrl_two;
			seq                              <= next_seq;
			primary_compare_value            <= next_primary_compare_value;
			secondary_compare_value          <= next_secondary_compare_value;
			timer_period                     <= next_timer_period;
			primary_shadow                   <= next_primary_shadow;
			secondary_shadow                 <= next_secondary_shadow;
			fault_active                     <= next_fault_active;
			compare_output_pin_out           <= next_pin;
			compare_event_out                <= next_event;
			rdata_out                        <= next_rdata;
		end
	end

endmodule : ocpwm_unit

`default_nettype wire

// ===== logic/ocpwm_params.svh
// Constants for the output compare and PWM channel: offsets, fields, resets, encodings
//
// Behaviour
// - PWM modes drive the waveform only from hidden shadow copies of duty values.
// - Each PWM period lasts timer period value plus one time-base counts.
// - Compare values written anytime load into shadows only when count equals period.
// - Primary, secondary and period all zero hold the output low.
// - Secondary value above the period holds the output high.
// - Idle halt control set stops the channel while the CPU idles.
// - Time base select picks system clock, Timer1..Timer5; 110 and 101 reserved.
// - Fault zero input enable gates whether the fault input is honoured.
// - Fault status flag is set by hardware on a fault, only in mode 111.
// - With clear mode set, secondary match or software clears trigger status.
// - Mode 111 is center-aligned PWM, mode 110 edge-aligned PWM.
// - Mode 101 starts low, toggles on alternating primary and secondary matches.
// - Mode 100 starts low, toggles on primary then secondary match, once.
// - Mode 011 toggles the output on every compare event.
// - Mode 010 starts high and goes low on the compare event.
// - Mode 001 starts low and goes high on the compare event.
// - Mode 000 disables the channel.
// - Fault pin A serves channels one to four, pin B five to nine.
// - Shadow buffering only in PWM modes; otherwise writes act directly.
// - Unimplemented control bits read as zero.
// - Fault hold mode picks end of fault: new period, or flag cleared by software.
// - During a fault the output follows the fault output level bit.
`ifndef OCPWM_PARAMS_SVH
`define OCPWM_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OCPWM_ADDR_CTRL_ONE   4'h0
`define OCPWM_ADDR_CTRL_TWO   4'h1
`define OCPWM_ADDR_PRIMARY    4'h2
`define OCPWM_ADDR_SECONDARY  4'h3
`define OCPWM_ADDR_PERIOD     4'h4
`define OCPWM_ADDR_COUNT      4'h5

// ----------------------------------------
// Field positions, first control register
// ----------------------------------------
`define OCPWM_C1_IDLE_BIT     13
`define OCPWM_C1_TSEL_HI      12
`define OCPWM_C1_TSEL_LO      10
`define OCPWM_C1_FLTEN_BIT    7
`define OCPWM_C1_FLAG_BIT     4
`define OCPWM_C1_TRIGMD_BIT   3
`define OCPWM_C1_MODE_HI      2
`define OCPWM_C1_MODE_LO      0

// ----------------------------------------
// Field positions, second control register
// ----------------------------------------
`define OCPWM_C2_HOLD_BIT     15
`define OCPWM_C2_LEVEL_BIT    14
`define OCPWM_C2_TRIGSEL_BIT  7
`define OCPWM_C2_STAT_BIT     6
`define OCPWM_C2_SYNC_HI      4
`define OCPWM_C2_SYNC_LO      0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OCPWM_CTRL_ONE_RST    10'h000
`define OCPWM_SYNC_SEL_RST    5'h0C
`define OCPWM_WORD_RST        16'h0000

// ----------------------------------------
// Encodings
// ----------------------------------------
`define OCPWM_MODE_OFF        3'h0
`define OCPWM_MODE_SS_HIGH    3'h1
`define OCPWM_MODE_SS_LOW     3'h2
`define OCPWM_MODE_TOGGLE     3'h3
`define OCPWM_MODE_DBL_ONE    3'h4
`define OCPWM_MODE_DBL_CONT   3'h5
`define OCPWM_MODE_PWM_EDGE   3'h6
`define OCPWM_MODE_PWM_CENTER 3'h7
`define OCPWM_TSEL_SYSCLK     3'h7
`define OCPWM_TSEL_TIMER1     3'h4
`define OCPWM_SYNC_NONE       5'h00
`define OCPWM_SYNC_SELF       5'h1F
`define OCPWM_FAULT_A_LAST    4

`endif

// ===== logic/ocpwm_pkg.sv
// Types shared by the output compare and PWM channel
package ocpwm_pkg;

	// ----------------------------------------
	// Control register images
	// ----------------------------------------
	typedef struct packed {
		logic       idle_halt_control;
		logic [2:0] time_base_select;
		logic       fault_zero_input_enable;
		logic       pwm_fault_status_flag;
		logic       trigger_status_clear_mode;
		logic [2:0] compare_mode_select;
	} ocpwm_ctrl_one_t;

	typedef struct packed {
		logic       fault_hold_mode;
		logic       fault_output_level;
		logic       trigger_or_sync_select;
		logic       trigger_running_status;
		logic [4:0] sync_source_select;
	} ocpwm_ctrl_two_t;

	// ----------------------------------------
	// Double compare sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		OCPWM_WAIT_PRIMARY,
		OCPWM_WAIT_SECONDARY,
		OCPWM_DONE
	} ocpwm_seq_t;

endpackage : ocpwm_pkg

// ===== logic/ocpwm_sync2.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module ocpwm_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// Reset to all ones: fault pins idle high
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stage_one <= '1;
			sync_out  <= '1;
		end else begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end

endmodule : ocpwm_sync2

`default_nettype wire

// ===== logic/ocpwm_time_base.sv
// Tick selection and internal counter of the channel
`timescale 1ns/1ps
`default_nettype none
`include "ocpwm_params.svh"

module ocpwm_time_base (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Tick sources: Timer2, Timer3, Timer4, Timer5, Timer1
	input  wire logic [4:0]  timer_tick_in,
	input  wire logic [2:0]  time_base_select_in,
	// Control
	input  wire logic        halt_in,
	input  wire logic        hold_clear_in,
	input  wire logic        sync_reset_in,
	input  wire logic [15:0] timer_period_in,
	// Results
	output logic             tick_out,
	output logic             period_end_out,
	output logic      [15:0] count_out
);

	logic [15:0] next_count;

	// ----------------------------------------
	// Tick select
	// ----------------------------------------
	always_comb begin
		tick_out = 1'b0;
		if (halt_in) begin
			tick_out = 1'b0;
		end else if (time_base_select_in == `OCPWM_TSEL_SYSCLK) begin
			tick_out = 1'b1;
		end else if (time_base_select_in <= `OCPWM_TSEL_TIMER1) begin
			tick_out = timer_tick_in[time_base_select_in];
		end
		period_end_out = tick_out && (count_out == timer_period_in);
	end

	// ----------------------------------------
	// Counter, wraps after period plus one ticks
	// ----------------------------------------
	always_comb begin
		next_count = count_out;
		if (hold_clear_in || sync_reset_in) begin
			next_count = 16'h0000;
		end else if (period_end_out) begin
			next_count = 16'h0000;
		end else if (tick_out) begin
			next_count = count_out + 16'h0001;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			count_out <= 16'h0000;
		end else begin
			count_out <= next_count;
		end
	end

endmodule : ocpwm_time_base

`default_nettype wire

// ===== test/ocpwm_checker.sv
// Port assertions for the compare channel
`timescale 1ns/1ps
`default_nettype none

module ocpwm_checker (
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        nrst_in,
	// Register port
	input wire logic [3:0]  addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [15:0] rdata_out,
	// System and output
	input wire logic        cpu_idle_in,
	input wire logic        compare_output_pin_out,
	input wire logic        compare_event_out
);
	logic [6:0] cfg;
	logic [6:0] next_cfg;
	logic       wr_c1;

	// ----------------------------------------
	// Mirror of idle, time base and mode fields
	// ----------------------------------------
	assign wr_c1 = wr_in && addr_in == 4'h0;
	always_comb begin
		next_cfg = wr_c1 ? {wdata_in[13:10], wdata_in[2:0]} : cfg;
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			cfg <= 7'h00;
		else
			cfg <= next_cfg;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	unimpl_bits_a: assert property ($past(rd_in) && $past(addr_in) == 4'h0
		|-> (rdata_out & 16'hC360) == 16'h0000) else $error("reserved bits set");
	unmapped_read_a: assert property ($past(rd_in) && $past(addr_in) > 4'h5
		|-> rdata_out == 16'h0000) else $error("unmapped read not zero");
	off_quiet_a: assert property (cfg[2:0] == 3'h0 && $past(cfg[2:0]) == 3'h0
		&& $past(cfg[2:0], 2) == 3'h0 |-> !compare_output_pin_out && !compare_event_out)
		else $error("disabled channel active");
	high_init_a: assert property (wr_c1 && wdata_in[2:0] == 3'h2
		|=> compare_output_pin_out) else $error("pin not high after mode write");
	low_init_a: assert property (wr_c1 && wdata_in[2:0] inside {3'h1, 3'h4, 3'h5}
		|=> !compare_output_pin_out) else $error("pin not low after mode write");
	idle_freeze_a: assert property ((cfg[6] && cpu_idle_in && !wr_in)[*3]
		|-> $stable(compare_output_pin_out) && !compare_event_out) else $error("ran in idle");
	reserved_tb_a: assert property ((cfg[5:3] inside {3'h5, 3'h6} && !wr_in)[*3]
		|-> $stable(compare_output_pin_out) && !compare_event_out) else $error("reserved ticked");
	toggle_event_a: assert property (cfg[2:0] == 3'h3 && $past(cfg[2:0]) == 3'h3 && !$past(wr_in)
		|-> compare_event_out == (compare_output_pin_out != $past(compare_output_pin_out)))
		else $error("toggle without event");

	cover property (wr_c1 && wdata_in[2:0] == 3'h7);
	cover property (compare_event_out && cfg[2:0] == 3'h5);
	cover property (cfg[6] && cpu_idle_in);
endmodule : ocpwm_checker

`default_nettype wire

// ===== test/ocpwm_load_model.sv
// Load on the channel output and fault source
`timescale 1ns/1ps
`default_nettype none

module ocpwm_load_model (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Channel side
	input  wire logic        pin_in,
	output logic             fault_n_out,
	// Bench side
	input  wire logic        fault_req_in,
	input  wire logic        clr_in,
	output logic      [15:0] high_cnt_out,
	output logic      [15:0] edge_cnt_out
);
	logic last;

	// Fault line has a pull-up, so idle reads high
	assign fault_n_out = !fault_req_in;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			high_cnt_out <= 16'h0000;
			edge_cnt_out <= 16'h0000;
			last <= 1'b0;
		end else begin
			last <= pin_in;
			high_cnt_out <= clr_in ? 16'h0000 : high_cnt_out + {15'h0, pin_in};
			edge_cnt_out <= clr_in ? 16'h0000 : edge_cnt_out + {15'h0, pin_in != last};
		end
	end
endmodule : ocpwm_load_model

`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the compare channel
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        clk_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic [3:0]  addr_in = 4'h0;
	logic [15:0] wdata_in = 16'h0000;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [4:0]  tick = 5'h1F;
	logic        cpu_idle = 1'b0;
	logic        fault_req = 1'b0;
	logic        fault_b_n = 1'b1;
	logic        clr = 1'b0;
	logic        fault_a_n, pin, evt;
	logic [15:0] rdata_out, high_cnt, edge_cnt, rd_val, sv;
	logic [31:0] seed = 32'h867B;
	int          n_fail = 0;
	int          n_compared = 0;

	always #2 clk_in = ~clk_in;

	ocpwm_unit dut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.timer_tick_in(tick), .cpu_idle_in(cpu_idle), .sync_event_in(1'b0),
		.trigger_event_in(1'b0), .fault_pin_a_n_in(fault_a_n), .fault_pin_b_n_in(fault_b_n),
		.compare_output_pin_out(pin), .compare_event_out(evt));
	ocpwm_load_model load (.clk_in, .nrst_in, .pin_in(pin),
		.fault_n_out(fault_a_n), .fault_req_in(fault_req), .clr_in(clr),
		.high_cnt_out(high_cnt), .edge_cnt_out(edge_cnt));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	// Flag bit is set by hardware only
	function automatic logic [15:0] c1_img(input logic [15:0] d);
		return d & 16'h3C8F;
	endfunction : c1_img

	function automatic logic [15:0] edge_exp(input int m);
		return (m < 3) ? 16'h0001 : (m == 3) ? 16'h0004 : (m == 4) ? 16'h0002 : 16'h0008;
	endfunction : edge_exp

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 rd_val = rdata_out;
	endtask : rd

	task automatic win(input int w, input int n);
		repeat (w) @(posedge clk_in);
		@(posedge clk_in);
		clr <= 1'b1;
		@(posedge clk_in);
		clr <= 1'b0;
		repeat (n) @(posedge clk_in);
		#1;
	endtask : win

	task automatic duty(input logic [15:0] c1, p, s, per, exp);
		wr(4'h0, 16'h1C00);
		wr(4'h2, p);
		wr(4'h3, s);
		wr(4'h4, per);
		wr(4'h0, c1);
		win(20, 100);
		chk("high time", exp, high_cnt);
	endtask : duty

	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk_in);
		nrst_in <= 1'b1;
		for (int a = 0; a < 8; a++) begin
			rd(a[3:0]);
			chk("reset word", (a == 1) ? 16'h000C : 16'h0000, rd_val);
		end
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			wr(4'h0, seed[15:0]);
			rd(4'h0);
			chk("ctrl one", c1_img(seed[15:0]), rd_val);
			wr(4'h2, seed[31:16]);
			rd(4'h2);
			chk("primary", seed[31:16], rd_val);
		end
		wr(4'h1, 16'h001F);
		wr(4'h2, 16'h0004);
		wr(4'h3, 16'h0007);
		wr(4'h4, 16'h0009);
		for (int m = 1; m < 6; m++) begin
			wr(4'h0, 16'h1C00);
			wr(4'h0, 16'h1C00 | m[15:0]);
			win(0, 40);
			chk("edges", edge_exp(m), edge_cnt);
			chk("last level", {15'h0000, m == 1}, {15'h0000, pin});
		end
		duty(16'h1C06, 16'h0000, 16'h0004, 16'h0009, 16'h0028);
		duty(16'h1C07, 16'h0002, 16'h0007, 16'h0009, 16'h0032);
		duty(16'h1C06, 16'h0000, 16'h000C, 16'h0009, 16'h0064);
		duty(16'h1C06, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		wr(4'h4, 16'h0009);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			sv = 16'(seed % 32'hA);
			wr(4'h3, sv);
			win(20, 100);
			chk("duty", sv * 16'h000A, high_cnt);
		end
		wr(4'h3, 16'h0004);
		for (int t = 0; t < 6; t++) begin
			tick <= (t == 5) ? 5'h1F : 5'h01 << t;
			wr(4'h0, {3'h0, t[2:0], 10'h006});
			win(20, 100);
			chk("tick edges", (t == 5) ? 16'h0000 : 16'h0014, edge_cnt);
		end
		tick <= 5'h1F;
		cpu_idle <= 1'b1;
		wr(4'h0, 16'h3C06);
		win(0, 100);
		chk("idle edges", 16'h0000, edge_cnt);
		wr(4'h0, 16'h1C06);
		win(0, 100);
		chk("busy edges", 16'h0014, edge_cnt);
		cpu_idle <= 1'b0;
		wr(4'h1, 16'h401F);
		fault_b_n <= 1'b0;
		duty(16'h1C87, 16'h0002, 16'h0007, 16'h0009, 16'h0032);
		fault_b_n <= 1'b1;
		fault_req <= 1'b1;
		duty(16'h1C07, 16'h0002, 16'h0007, 16'h0009, 16'h0032);
		wr(4'h0, 16'h1C87);
		win(10, 100);
		chk("fault level", 16'h0064, high_cnt);
		rd(4'h0);
		chk("fault flag", 16'h1C97, rd_val);
		fault_req <= 1'b0;
		repeat (30) @(posedge clk_in);
		rd(4'h0);
		chk("flag auto clear", 16'h1C87, rd_val);
		wr(4'h1, 16'hC01F);
		fault_req <= 1'b1;
		repeat (10) @(posedge clk_in);
		fault_req <= 1'b0;
		win(30, 100);
		chk("held fault", 16'h0064, high_cnt);
		wr(4'h0, 16'h1C87);
		win(30, 100);
		chk("fault over", 16'h0032, high_cnt);
		close_out();
	end

	initial begin
		repeat (30000) @(posedge clk_in);
		n_fail++;
		close_out();
	end
endmodule : testbench

bind ocpwm_unit ocpwm_checker chk_u (.*);

`default_nettype wire
